// ---- hdl/usbdc_top.v ----
// APB register front of the USB device endpoint control block
//
// Behaviour
// - Writing 1 clears matching port pending bit
// - Endpoint reset zeroes pointers, count, toggle
// - Endpoint reset keeps status flags untouched
// - IN done set on host ack, write-0 clears
// - Bank 0 full set on store, write-0 releases
// - Setup flag set on setup, write-0 acknowledges
// - Data OUT refused on control endpoints while setup flag set
// - Stall acknowledged flag, write-0 clears
// - Isochronous: bit 3 reports CRC error
// - Payload ready held until IN, then cleared
// - Writing 0 to payload ready cancels
// - Endpoint pending while any flag set
// - Bank 1 full behaves like bank 0
// - Direction bit selects control data stage
// - Control endpoints always read enabled
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "usbdc_defines.vh"

module usbdc_top #(
  parameter NUM_EP    = `USBDC_NUM_EP,
  parameter DUAL_BANK = `USBDC_DUAL_BANK_INIT
) (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [`USBDC_ADDR_W-1:0]  paddr,
  input  wire [31:0]               pwdata,
  output reg  [31:0]               prdata,
  output reg                       pready,
  output reg                       pslverr,
  input  wire [5:0]                portEvent,
  input  wire [NUM_EP-1:0]         inAckEvent,
  input  wire [NUM_EP-1:0]         bank0StoreEvent,
  input  wire [NUM_EP-1:0]         bank1StoreEvent,
  input  wire [NUM_EP-1:0]         setupStoreEvent,
  input  wire [NUM_EP-1:0]         stallAckEvent,
  input  wire [NUM_EP-1:0]         crcErrorEvent,
  input  wire [NUM_EP-1:0]         inSentEvent,
  input  wire [NUM_EP-1:0]         toggleEvent,
  input  wire [`USBDC_COUNT_W-1:0] rxCountIn,
  output reg  [5:0]                portPending,
  output reg  [NUM_EP-1:0]         endpointPending,
  output reg  [NUM_EP-1:0]         fifoPtrReset,
  output reg  [NUM_EP-1:0]         payloadReady,
  output reg  [NUM_EP-1:0]         haltRequest,
  output reg  [NUM_EP-1:0]         outRefused,
  output reg  [NUM_EP-1:0]         dataStageIn,
  output reg  [NUM_EP-1:0]         endpointEnabled
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  function isCsr;
    input [`USBDC_ADDR_W-1:0] a;
    begin
      isCsr = (a >= `USBDC_OFS_CSR_BASE) && (a <= `USBDC_OFS_CSR_LAST) && (a[1:0] == 2'h0);
    end
  endfunction

  function [2:0] csrIndex;
    input [`USBDC_ADDR_W-1:0] a;
    reg [`USBDC_ADDR_W-1:0] d;
    begin
      d        = a - `USBDC_OFS_CSR_BASE;
      csrIndex = d[4:2];
    end
  endfunction

  function isMapped;
    input [`USBDC_ADDR_W-1:0] a;
    begin
      isMapped = (a == `USBDC_OFS_PORT_CLEAR) || (a == `USBDC_OFS_FIFO_RESET) ||
                 (a == `USBDC_OFS_PORT_STATUS) || isCsr(a);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, then pready for one cycle

  wire       access    = psel & penable;
  wire       answer    = access & ~pready;
  wire       take      = access & pready;
  wire       takeWrite = take & pwrite & ~pslverr;
  wire       selCsr    = isCsr(paddr);
  wire [2:0] selIndex  = csrIndex(paddr);

  reg  [5:0]        fifoReset;
  reg               applyValid;
  reg  [2:0]        applyIndex;
  reg  [31:0]       applyData;
  wire [31:0]       csrWord [0:NUM_EP-1];
  wire [NUM_EP-1:0] epPending;
  wire [NUM_EP-1:0] epControl;

  reg  [31:0] readValue;
  integer     k;

  always @*
  begin
    readValue = 32'h00000000;
    if (paddr == `USBDC_OFS_FIFO_RESET)
      readValue[`USBDC_EP_MSB:`USBDC_EP_LSB] = fifoReset;
    else if (paddr == `USBDC_OFS_PORT_STATUS)
    begin
      readValue[`USBDC_PORT_MSB:`USBDC_PORT_LSB] = portPending;
      readValue[`USBDC_EP_LSB+NUM_EP-1:`USBDC_EP_LSB] = endpointPending;
    end
    else if (selCsr)
    begin
      for (k = 0; k < NUM_EP; k = k + 1)
        if (selIndex == k[2:0])
          readValue = csrWord[k];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= answer;
      // Unmapped offsets answer with an error and read zero
      pslverr <= answer & ~isMapped(paddr);
      prdata  <= (answer & ~pwrite) ? readValue : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pending bits and endpoint reset

  wire [5:0] portClear = (takeWrite && paddr == `USBDC_OFS_PORT_CLEAR) ?
                         pwdata[`USBDC_PORT_MSB:`USBDC_PORT_LSB] : 6'h00;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      portPending <= 6'h00;
      fifoReset   <= `USBDC_FIFO_RESET_INIT;
    end
    else
    begin
      // An event in the clearing cycle stays pending
      portPending <= (portPending & ~portClear) | portEvent;
      // Level held by software until it writes zero
      if (takeWrite && paddr == `USBDC_OFS_FIFO_RESET)
        fifoReset <= pwdata[`USBDC_EP_MSB:`USBDC_EP_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word writes are staged and applied one cycle after the bus
  // takes them, within the next access's setup phase, so readback never lags

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      applyValid <= 1'b0;
      applyIndex <= 3'h0;
      applyData  <= 32'h00000000;
    end
    else
    begin
      applyValid <= takeWrite & selCsr;
      if (takeWrite & selCsr)
      begin
        applyIndex <= selIndex;
        applyData  <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Endpoints

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1)
    begin : gEp
      usbdc_endpoint #(
        .DUAL_BANK (DUAL_BANK[g])
      ) uEndpoint (
        .clk           (clk),
        .rst           (rst),
        .wrStrobe      (applyValid && applyIndex == g),
        .wrData        (applyData),
        // Seen-marking uses the same cycle as the read data capture
        .readStrobe    (answer && !pwrite && selCsr && selIndex == g),
        .fifoReset     (fifoReset[g]),
        .inAckEvent    (inAckEvent[g]),
        .bank0Event    (bank0StoreEvent[g]),
        .bank1Event    (bank1StoreEvent[g]),
        .setupEvent    (setupStoreEvent[g]),
        .stallAckEvent (stallAckEvent[g]),
        .crcErrorEvent (crcErrorEvent[g]),
        .inSentEvent   (inSentEvent[g]),
        .toggleEvent   (toggleEvent[g]),
        .rxCountIn     (rxCountIn),
        .csrWord       (csrWord[g]),
        .pending       (epPending[g]),
        .isControl     (epControl[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Engine-facing copies, registered

  integer e;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      endpointPending <= {NUM_EP{1'b0}};
      fifoPtrReset    <= {NUM_EP{1'b0}};
      payloadReady    <= {NUM_EP{1'b0}};
      haltRequest     <= {NUM_EP{1'b0}};
      outRefused      <= {NUM_EP{1'b0}};
      dataStageIn     <= {NUM_EP{1'b0}};
      endpointEnabled <= {NUM_EP{1'b0}};
    end
    else
    begin
      endpointPending <= epPending;
      fifoPtrReset    <= fifoReset[NUM_EP-1:0];
      for (e = 0; e < NUM_EP; e = e + 1)
      begin
        payloadReady[e]    <= csrWord[e][`USBDC_BIT_PAY_READY];
        haltRequest[e]     <= csrWord[e][`USBDC_BIT_HALT];
        dataStageIn[e]     <= csrWord[e][`USBDC_BIT_DIR];
        endpointEnabled[e] <= csrWord[e][`USBDC_BIT_ENABLE];
        // The store event is folded in so the refusal has no gap
        outRefused[e]      <= epControl[e] &
                              (csrWord[e][`USBDC_BIT_SETUP] | setupStoreEvent[e]);
      end
    end
  end

endmodule

// ---- include/usbdc_defines.vh ----
// Register offsets, field positions and reset values of the endpoint control block
`ifndef USBDC_DEFINES_VH
`define USBDC_DEFINES_VH

`define USBDC_ADDR_W          8
`define USBDC_DATA_W          32
`define USBDC_NUM_EP          6

`define USBDC_OFS_PORT_CLEAR  8'h00
`define USBDC_OFS_FIFO_RESET  8'h04
`define USBDC_OFS_PORT_STATUS 8'h08
`define USBDC_OFS_CSR_BASE    8'h30
`define USBDC_OFS_CSR_LAST    8'h44

`define USBDC_PORT_LSB        8
`define USBDC_PORT_MSB        13
`define USBDC_EP_LSB          0
`define USBDC_EP_MSB          5

`define USBDC_BIT_IN_DONE     0
`define USBDC_BIT_BANK0       1
`define USBDC_BIT_SETUP       2
`define USBDC_BIT_STALL_ISO   3
`define USBDC_BIT_PAY_READY   4
`define USBDC_BIT_HALT        5
`define USBDC_BIT_BANK1       6
`define USBDC_BIT_DIR         7
`define USBDC_KIND_LSB        8
`define USBDC_KIND_MSB        10
`define USBDC_BIT_TOGGLE      11
`define USBDC_BIT_ENABLE      15
`define USBDC_COUNT_LSB       16
`define USBDC_COUNT_MSB       26
`define USBDC_COUNT_W         11

`define USBDC_KIND_CONTROL    3'h0
`define USBDC_KIND_ISO_LOW    2'h1
`define USBDC_KIND_RESET      3'h0
`define USBDC_FIFO_RESET_INIT 6'h00
`define USBDC_DUAL_BANK_INIT  6'h3e

`endif

// ---- hdl/usbdc_endpoint.v ----
// Control and status word of one endpoint
`timescale 1ns/1ps
`include "usbdc_defines.vh"

module usbdc_endpoint #(
  parameter DUAL_BANK = 1'b1
) (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      wrStrobe,
  input  wire [31:0]               wrData,
  input  wire                      readStrobe,
  input  wire                      fifoReset,
  input  wire                      inAckEvent,
  input  wire                      bank0Event,
  input  wire                      bank1Event,
  input  wire                      setupEvent,
  input  wire                      stallAckEvent,
  input  wire                      crcErrorEvent,
  input  wire                      inSentEvent,
  input  wire                      toggleEvent,
  input  wire [`USBDC_COUNT_W-1:0] rxCountIn,
  output wire [31:0]               csrWord,
  output wire                      pending,
  output wire                      isControl
);

  reg                      inDone;
  reg                      bank0;
  reg                      bank1;
  reg                      setup;
  reg                      stallIso;
  reg                      payReady;
  reg                      halt;
  reg                      dirIn;
  reg [2:0]                kind;
  reg                      toggle;
  reg                      enable;
  reg [`USBDC_COUNT_W-1:0] byteCount;
  reg [4:0]                seen;

  wire isIso      = (kind[1:0] == `USBDC_KIND_ISO_LOW);
  wire stallIsoEv = isIso ? crcErrorEvent : stallAckEvent;
  wire bank1Ev    = DUAL_BANK ? bank1Event : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Write 0 clears only a flag that a read has shown as set, so a stale
  // read-modify-write cannot wipe a fresh event; a new event beats a clear
  function [1:0] stepFlag;
    input flag;
    input seenBit;
    input wr;
    input wbit;
    input ev;
    input rd;
    reg clr;
    reg nf;
    begin
      clr      = wr & ~wbit & seenBit;
      nf       = ev | (flag & ~clr);
      stepFlag = {nf, nf & ~clr & (seenBit | (rd & flag))};
    end
  endfunction

  wire [1:0] stepInDone = stepFlag(inDone, seen[0], wrStrobe, wrData[`USBDC_BIT_IN_DONE],
                                   inAckEvent, readStrobe);
  wire [1:0] stepBank0  = stepFlag(bank0, seen[1], wrStrobe, wrData[`USBDC_BIT_BANK0],
                                   bank0Event, readStrobe);
  wire [1:0] stepSetup  = stepFlag(setup, seen[2], wrStrobe, wrData[`USBDC_BIT_SETUP],
                                   setupEvent, readStrobe);
  wire [1:0] stepStall  = stepFlag(stallIso, seen[3], wrStrobe, wrData[`USBDC_BIT_STALL_ISO],
                                   stallIsoEv, readStrobe);
  wire [1:0] stepBank1  = stepFlag(bank1, seen[4], wrStrobe, wrData[`USBDC_BIT_BANK1],
                                   bank1Ev, readStrobe);

  wire wrKindCtl = (wrData[`USBDC_KIND_MSB:`USBDC_KIND_LSB] == `USBDC_KIND_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inDone    <= 1'b0;
      bank0     <= 1'b0;
      bank1     <= 1'b0;
      setup     <= 1'b0;
      stallIso  <= 1'b0;
      payReady  <= 1'b0;
      halt      <= 1'b0;
      dirIn     <= 1'b0;
      kind      <= `USBDC_KIND_RESET;
      toggle    <= 1'b0;
      enable    <= 1'b0;
      byteCount <= {`USBDC_COUNT_W{1'b0}};
      seen      <= 5'h00;
    end
    else
    begin
      // Endpoint reset leaves these flags alone
      inDone   <= stepInDone[1];
      bank0    <= stepBank0[1];
      bank1    <= stepBank1[1];
      setup    <= stepSetup[1];
      stallIso <= stepStall[1];
      seen     <= {stepBank1[0], stepStall[0], stepSetup[0], stepBank0[0], stepInDone[0]};
      // Software set wins over the engine's clear after sending
      if (wrStrobe & wrData[`USBDC_BIT_PAY_READY])
        payReady <= 1'b1;
      else if (inSentEvent | wrStrobe)
        payReady <= 1'b0;
      if (wrStrobe)
      begin
        halt  <= wrData[`USBDC_BIT_HALT];
        dirIn <= wrData[`USBDC_BIT_DIR];
        kind  <= wrData[`USBDC_KIND_MSB:`USBDC_KIND_LSB];
        if (!wrKindCtl)
          enable <= wrData[`USBDC_BIT_ENABLE];
      end
      if (fifoReset)
      begin
        toggle    <= 1'b0;
        byteCount <= {`USBDC_COUNT_W{1'b0}};
      end
      else
      begin
        if (toggleEvent)
          toggle <= ~toggle;
        if (bank0Event | bank1Ev)
          byteCount <= rxCountIn;
      end
    end
  end

  assign isControl = (kind == `USBDC_KIND_CONTROL);
  assign pending   = inDone | bank0 | bank1 | setup | stallIso;
  assign csrWord   = {5'h00, byteCount, enable | isControl, 3'h0, toggle, kind, dirIn,
                      bank1, halt, payReady, stallIso, setup, bank0, inDone};

endmodule

// ---- testbench/usbdc_top_asserts.sv ----
// Port-level checks of the endpoint control block
`timescale 1ns/1ps
module usbdc_top_asserts #(
  parameter NUM_EP = 6
) (
  input wire              clk,
  input wire              rst,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [7:0]        paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire [5:0]        portEvent,
  input wire [NUM_EP-1:0] inAckEvent,
  input wire [NUM_EP-1:0] bank0StoreEvent,
  input wire [NUM_EP-1:0] setupStoreEvent,
  input wire [5:0]        portPending,
  input wire [NUM_EP-1:0] endpointPending,
  input wire [NUM_EP-1:0] fifoPtrReset,
  input wire [NUM_EP-1:0] payloadReady,
  input wire [NUM_EP-1:0] outRefused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire              wr = psel && penable && pready && pwrite;
  wire [NUM_EP-1:0] evAny = inAckEvent | bank0StoreEvent | setupStoreEvent;
  ////////////////////////////////////////
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing");
  a_err_refused: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  a_port_set: assert property
    (|portEvent |=> (portPending & $past(portEvent)) == $past(portEvent)) else $error("no set");
  a_port_clear: assert property (wr && paddr == 8'h00 |=>
    (portPending & $past(pwdata[13:8]) & ~$past(portEvent)) == 6'h00) else $error("no clear");
  a_port_keep: assert property (!(wr && paddr == 8'h00) |=>
    (portPending & $past(portPending)) == $past(portPending)) else $error("port bit lost");
  a_fifo_copy: assert property (wr && paddr == 8'h04 |-> ##2
    fifoPtrReset == $past(pwdata[NUM_EP-1:0], 2)) else $error("fifo reset copy");
  a_pend_flag: assert property (|evAny |-> ##2
    (endpointPending & $past(evAny, 2)) == $past(evAny, 2)) else $error("pending late");
  a_setup_refuse: assert property (setupStoreEvent[0] |=> outRefused[0])
    else $error("out not refused");
  a_ready_lag: assert property (wr && paddr == 8'h30 && pwdata[4] |-> ##3 payloadReady[0])
    else $error("ready not taken up");
  cover property (pslverr);
  cover property (|outRefused);
  cover property ($fell(payloadReady[0]));
endmodule
bind usbdc_top usbdc_top_asserts #(.NUM_EP(NUM_EP)) i_usbdc_top_asserts (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .portEvent, .inAckEvent,
  .bank0StoreEvent, .setupStoreEvent, .portPending, .endpointPending, .fifoPtrReset,
  .payloadReady, .outRefused);

// ---- testbench/usbdc_host_model.sv ----
// Host stand-in: takes a ready IN payload and acknowledges it
`timescale 1ns/1ps
module usbdc_host_model (
  input  wire       clk,
  input  wire       rst,
  input  wire       slow,
  input  wire [5:0] payloadReady,
  output reg  [5:0] inSentEvent,
  output reg  [5:0] inAckEvent
);
  reg     [3:0] cnt;
  reg     [2:0] ep;
  reg     [1:0] phase;
  integer       i;
  ////////////////////////////////////////
  always @(posedge clk or posedge rst)
  begin
    inSentEvent <= 6'h00;
    inAckEvent  <= 6'h00;
    if (rst)
    begin
      cnt   <= 4'h0;
      ep    <= 3'h0;
      phase <= 2'h0;
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (phase == 2'h0 && payloadReady != 6'h00)
    begin
      for (i = 5; i >= 0; i = i - 1)
        if (payloadReady[i])
          ep <= i[2:0];
      phase <= 2'h1;
      cnt   <= slow ? 4'hf : 4'h1;
    end
    else if (phase == 2'h1)
    begin
      // Token finds data only while the device still holds it
      inSentEvent[ep] <= payloadReady[ep];
      phase           <= payloadReady[ep] ? 2'h2 : 2'h0;
    end
    else if (phase == 2'h2)
    begin
      inAckEvent[ep] <= 1'b1;
      phase          <= 2'h0;
      // Ready copy lags its clear; avoids sending twice
      cnt            <= 4'h4;
    end
  end
endmodule

// ---- testbench/usbdc_top_tb.sv ----
// Self-checking bench of the endpoint control block
`timescale 1ns/1ps
module usbdc_top_tb;
  reg         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rnd = 32'h6e35, rdat;
  reg  [10:0] rxCnt = 11'h000;
  reg  [5:0]  portEvent = 6'h00, tbAck = 6'h00, bank0 = 6'h00, bank1 = 6'h00, m;
  reg  [5:0]  setup = 6'h00, stall = 6'h00, crc = 6'h00, tog = 6'h00;
  reg         rerr;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire [5:0]  hostAck, inSent, portPending, endpointPending, fifoPtrReset, payloadReady;
  wire [5:0]  haltRequest, outRefused, dataStageIn, endpointEnabled;
  integer     n_errors = 0, checks = 0, i, k;
  usbdc_top i_usbdc_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .portEvent, .inAckEvent(hostAck | tbAck), .bank0StoreEvent(bank0),
    .bank1StoreEvent(bank1), .setupStoreEvent(setup), .stallAckEvent(stall), .crcErrorEvent(crc),
    .inSentEvent(inSent), .toggleEvent(tog), .rxCountIn(rxCnt), .portPending, .endpointPending,
    .fifoPtrReset, .payloadReady, .haltRequest, .outRefused, .dataStageIn, .endpointEnabled);
  usbdc_host_model i_usbdc_host_model (.clk, .rst, .slow, .payloadReady,
    .inSentEvent(inSent), .inAckEvent(hostAck));
  initial
    forever #4 clk = ~clk;
  ////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Control kind always reads enabled
  function [31:0] csrw(input [10:0] c, input [2:0] kd, input tg, input en, input [7:0] fl);
    csrw = {5'h00, c, en | (kd == 3'h0), 3'h0, tg, kd, fl};
  endfunction
  task chk(input string n, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      if (n_errors == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (t = 0; pready !== 1'b1 && t < 16; t = t + 1)
        @(posedge clk);
      chk("pready", pready, 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk("prdata", rdat, e);
    end
  endtask
  task ev(input integer kd, input [5:0] v);
    begin
      @(posedge clk);
      case (kd)
        0: tbAck <= v;
        1: bank0 <= v;
        2: bank1 <= v;
        3: setup <= v;
        4: stall <= v;
        5: crc <= v;
        6: tog <= v;
        default: portEvent <= v;
      endcase
      @(posedge clk);
      {portEvent, tbAck, bank0, bank1, setup, stall, crc, tog} <= 48'h0;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    conclude;
  end
  initial
  begin
    step(8);
    rst <= 1'b0;
    for (i = 0; i < 6; i = i + 1)
      rdc(8'h30 + {i[5:0], 2'b00}, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h00));
    rdc(8'h04, 32'h0);
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h0);
    chk("pslverr", rerr, 1'b1);
    // First mask empty: zero bits must leave pending alone
    for (k = 0; k < 5; k = k + 1)
    begin
      rnd = lfsr(rnd);
      m = (k == 0) ? 6'h00 : rnd[5:0];
      ev(7, 6'h3f);
      apb(1'b1, 8'h00, {18'h0, m, 8'h00});
      step(1);
      chk("portPending", portPending, {26'h0, ~m});
      rdc(8'h08, {18'h0, ~m, 8'h00});
    end
    rnd = lfsr(rnd);
    rxCnt <= rnd[10:0];
    ev(1, 6'h02);
    ev(6, 6'h02);
    rdc(8'h34, csrw(rxCnt, 3'h0, 1'b1, 1'b0, 8'h02));
    apb(1'b1, 8'h04, 32'h2);
    // Register copy of the reset level lags the register by one more cycle
    step(2);
    chk("fifoPtrReset", fifoPtrReset, 6'h02);
    rdc(8'h34, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h02));
    apb(1'b1, 8'h34, 32'h0);
    rdc(8'h34, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h00));
    apb(1'b1, 8'h04, 32'h0);
    rdc(8'h04, 32'h0);
    rnd = lfsr(rnd);
    rxCnt <= rnd[10:0];
    for (k = 0; k < 5; k = k + 1)
      ev(k, 6'h04);
    step(2);
    chk("endpointPending", endpointPending, 6'h04);
    apb(1'b1, 8'h38, 32'h0);
    rdc(8'h38, csrw(rxCnt, 3'h0, 1'b0, 1'b0, 8'h4f));
    apb(1'b1, 8'h38, 32'h0);
    rdc(8'h38, csrw(rxCnt, 3'h0, 1'b0, 1'b0, 8'h00));
    chk("endpointPending", endpointPending, 6'h00);
    apb(1'b1, 8'h40, 32'h8100);
    ev(5, 6'h18);
    ev(4, 6'h18);
    rdc(8'h3c, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h08));
    rdc(8'h40, csrw(11'h0, 3'h1, 1'b0, 1'b1, 8'h08));
    chk("endpointEnabled", endpointEnabled, 6'h3f);
    apb(1'b1, 8'h40, 32'h0100);
    apb(1'b1, 8'h3c, 32'h0);
    rdc(8'h40, csrw(11'h0, 3'h1, 1'b0, 1'b0, 8'h00));
    rdc(8'h3c, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h00));
    chk("endpointEnabled", endpointEnabled, 6'h2f);
    apb(1'b1, 8'h44, 32'h10);
    k = 0;
    do
    begin
      apb(1'b0, 8'h44, 32'h0);
      k = k + 1;
    end
    while (rdat[0] !== 1'b1 && k < 30);
    chk("csrAfterIn", rdat, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h01));
    apb(1'b1, 8'h44, 32'h0);
    rdc(8'h44, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h00));
    slow <= 1'b1;
    apb(1'b1, 8'h30, 32'h10);
    apb(1'b1, 8'h30, 32'h0);
    step(3);
    chk("payloadReady", payloadReady, 6'h00);
    step(20);
    // Endpoint zero has a single bank, so this store must leave it clean
    ev(2, 6'h01);
    rdc(8'h30, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'h00));
    ev(3, 6'h01);
    step(1);
    chk("outRefused", outRefused, 6'h01);
    apb(1'b1, 8'h30, 32'ha0);
    step(3);
    chk("dataStageIn", dataStageIn, 6'h01);
    chk("haltRequest", haltRequest, 6'h01);
    rdc(8'h30, csrw(11'h0, 3'h0, 1'b0, 1'b0, 8'ha4));
    apb(1'b1, 8'h30, 32'h0);
    step(3);
    chk("outRefused", outRefused, 6'h00);
    chk("haltRequest", haltRequest, 6'h00);
    conclude;
  end
endmodule
